// ### hdl/tms_target.v
// Two-wire bus target: address match, shift register access, status
`timescale 1ns/1ps
`include "tms_map.vh"

module tms_target (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_in,
  output wire        scl_out,
  output wire        scl_oe,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe
);

  // ==========================================================
  // States and follow-up actions after an acknowledge bit
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_SHIFT = 5'h02;
  localparam [4:0] ST_MACK  = 5'h04;
  localparam [4:0] ST_HOLD  = 5'h08;
  localparam [4:0] ST_ACK   = 5'h10;
  localparam [1:0] AFT_IDLE = 2'h0;
  localparam [1:0] AFT_RX   = 2'h1;
  localparam [1:0] AFT_DHLD = 2'h2;

  function id_hit;
    input [6:0] a;
    input [6:0] pat;
    input [6:0] ign;
    begin
      id_hit = (((a ^ pat) & ~ign) == 7'h00);
    end
  endfunction

  // ==========================================================
  // Line watcher
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;

  tms_line_watch u_watch (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_s      (),
    .sda_s      (sda_s),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  // ==========================================================
  // State
  reg [4:0] state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg       is_addr;
  reg       dir;
  reg       addressed;
  reg       hold_src;
  reg [1:0] after_ack;
  reg       sda_drv;
  reg       match_or_halt_event_flag;
  reg       byte_done_event_flag;
  reg       cause;
  reg       illegal_condition_flag;
  reg       rxack;
  reg       host_en;
  reg       tgt_en;
  reg       ack_choice;
  reg [7:0] id_reg;
  reg [7:0] filt_reg;
  reg       rel_tail;

  // ==========================================================
  // APB decode: zero wait states, frozen by the clock enable
  wire [5:0] idx    = paddr[7:2];
  wire       mapped = (idx == `TMS_IDX_HOST_A) | (idx == `TMS_IDX_CTRL) |
                      (idx == `TMS_IDX_STATUS) | (idx == `TMS_IDX_ID) |
                      (idx == `TMS_IDX_SHIFT)  | (idx == `TMS_IDX_FILTER);
  wire       acc    = psel & penable & ce;
  wire       wr     = acc & pwrite & mapped;
  wire       rd     = acc & ~pwrite & mapped;

  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;

  wire       in_hold  = state[3];
  wire       dat_rd   = rd & (idx == `TMS_IDX_SHIFT);
  wire       dat_wr   = wr & (idx == `TMS_IDX_SHIFT);
  wire       ctl_wr   = wr & (idx == `TMS_IDX_CTRL);
  wire       st_wr    = wr & (idx == `TMS_IDX_STATUS);
  wire [1:0] cmd      = ctl_wr ? pwdata[1:0] : `TMS_CMD_NONE;
  wire       cmd_ok   = (cmd == `TMS_CMD_COMPLETE) | (cmd == `TMS_CMD_RESPOND);
  wire       touch    = dat_rd | dat_wr | cmd_ok;
  wire       go       = touch & in_hold;
  // Clock stays low one cycle past release so SDA is set up first
  wire       stretch  = in_hold | rel_tail;
  // Control write may change the ack choice in the same access
  wire       ack_now  = ctl_wr ? pwdata[`TMS_CTRL_ACK_BIT] : ack_choice;

  wire [7:0] status = {byte_done_event_flag, match_or_halt_event_flag, stretch, rxack, 1'b0, illegal_condition_flag, dir, cause};

  // Capture read data in the setup phase so it leaves a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (paddr[7:2])
        `TMS_IDX_HOST_A: prdata <= {31'h0000_0000, host_en};
        `TMS_IDX_CTRL:   prdata <= {28'h000_0000, tgt_en, ack_choice, 2'h0};
        `TMS_IDX_STATUS: prdata <= {24'h00_0000, status};
        `TMS_IDX_ID:     prdata <= {24'h00_0000, id_reg};
        `TMS_IDX_SHIFT:  prdata <= {24'h00_0000, shreg};
        `TMS_IDX_FILTER: prdata <= {24'h00_0000, filt_reg};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_en    <= 1'b0;
      tgt_en     <= 1'b0;
      ack_choice <= 1'b0;
      id_reg     <= `TMS_REG_RESET;
      filt_reg   <= `TMS_REG_RESET;
    end else if (wr) begin
      case (idx)
        `TMS_IDX_HOST_A: host_en <= pwdata[`TMS_HOST_EN_BIT];
        `TMS_IDX_CTRL: begin
          tgt_en     <= pwdata[`TMS_CTRL_EN_BIT];
          ack_choice <= pwdata[`TMS_CTRL_ACK_BIT];
        end
        `TMS_IDX_ID:     id_reg <= pwdata[7:0];
        `TMS_IDX_FILTER: filt_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Address recognition on the byte just shifted in
  wire sel2   = filt_reg[`TMS_FILT_SEL_BIT];
  // Mask mode: filter bits ignore id bits; dual mode: either id hits
  wire hit_m  = ~sel2 & id_hit(shreg[7:1], id_reg[7:1], filt_reg[7:1]);
  wire hit_d  = sel2 & (id_hit(shreg[7:1], id_reg[7:1], 7'h00) |
                        id_hit(shreg[7:1], filt_reg[7:1], 7'h00));
  // First ten-bit byte is simply another seven-bit pattern here
  wire hit_gc = id_reg[`TMS_ID_GCALL_BIT] & (shreg == 8'h00);
  wire a_hit  = hit_m | hit_d | hit_gc;

  // Start then stop with no bit in between, or a condition mid-byte
  // Receiving, a condition in a byte's first high phase is a legal end
  wire rx_side  = is_addr | ~dir;
  wire bad_stop = stop_seen & state[1] & is_addr & (bitcnt <= 4'h1);
  wire bad_mid  = (start_seen | stop_seen) & state[1] &
                  (rx_side ? (bitcnt >= 4'h2) : (bitcnt != 4'h0));
  wire bus_bad  = host_en & (bad_stop | bad_mid);

  // ==========================================================
  // Bus sequencer and flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      shreg     <= 8'h00;
      bitcnt    <= 4'h0;
      is_addr   <= 1'b0;
      dir       <= 1'b0;
      addressed <= 1'b0;
      hold_src  <= 1'b0;
      after_ack <= AFT_IDLE;
      sda_drv   <= 1'b0;
      match_or_halt_event_flag      <= 1'b0;
      byte_done_event_flag       <= 1'b0;
      cause     <= 1'b0;
      illegal_condition_flag    <= 1'b0;
      rxack     <= 1'b0;
      rel_tail  <= 1'b0;
    end else if (ce) begin
      // Clears come first so that a same-cycle set wins
      if (touch) begin
        match_or_halt_event_flag <= 1'b0;
        byte_done_event_flag  <= 1'b0;
      end
      if (st_wr) begin
        if (pwdata[`TMS_ST_DIF_BIT])
          byte_done_event_flag <= 1'b0;
        if (pwdata[`TMS_ST_MATCH_OR_HALT_EVENT_FLAG_BIT])
          match_or_halt_event_flag <= 1'b0;
        if (pwdata[`TMS_ST_ERR_BIT])
          illegal_condition_flag <= 1'b0;
      end
      if (dat_wr && in_hold)
        shreg <= pwdata[7:0];
      if (bus_bad)
        illegal_condition_flag <= 1'b1;
      rel_tail <= go;

      if (!tgt_en) begin
        state     <= ST_IDLE;
        sda_drv   <= 1'b0;
        addressed <= 1'b0;
      end else if (stop_seen) begin
        if (addressed) begin
          match_or_halt_event_flag  <= 1'b1;
          cause <= 1'b0;
        end
        addressed <= 1'b0;
        sda_drv   <= 1'b0;
        state     <= ST_IDLE;
      end else if (start_seen) begin
        is_addr <= 1'b1;
        bitcnt  <= 4'h0;
        sda_drv <= 1'b0;
        state   <= ST_SHIFT;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_drv <= 1'b0;
          end
          ST_SHIFT: begin
            if (is_addr || !dir) begin
              if (scl_rise && bitcnt != 4'h8) begin
                shreg  <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
              end else if (scl_fall && bitcnt == 4'h8) begin
                bitcnt <= 4'h0;
                if (!is_addr) begin
                  byte_done_event_flag      <= 1'b1;
                  hold_src <= 1'b0;
                  state    <= ST_HOLD;
                end else if (a_hit) begin
                  match_or_halt_event_flag      <= 1'b1;
                  cause     <= 1'b1;
                  dir       <= shreg[0];
                  addressed <= 1'b1;
                  hold_src  <= 1'b1;
                  is_addr   <= 1'b0;
                  state     <= ST_HOLD;
                end else begin
                  state <= ST_IDLE;
                end
              end
            end else if (scl_fall) begin
              // Transmit: same register shifts out towards the bus
              shreg  <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                sda_drv <= 1'b0;
                bitcnt  <= 4'h0;
                state   <= ST_MACK;
              end else begin
                sda_drv <= ~shreg[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise)
              rxack <= sda_s;
            else if (scl_fall) begin
              byte_done_event_flag      <= 1'b1;
              hold_src <= 1'b0;
              state    <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (go) begin
              if (cmd == `TMS_CMD_COMPLETE) begin
                if (!dir || hold_src) begin
                  sda_drv   <= ~ack_now;
                  after_ack <= AFT_IDLE;
                  state     <= ST_ACK;
                end else
                  state <= ST_IDLE;
              end else if (dir && !hold_src) begin
                // Next byte out: host acks it, no ack action from us
                sda_drv <= ~(dat_wr ? pwdata[7] : shreg[7]);
                bitcnt  <= 4'h0;
                state   <= ST_SHIFT;
              end else begin
                sda_drv <= ~ack_now;
                if (ack_now)
                  after_ack <= AFT_IDLE;
                else if (dir)
                  after_ack <= AFT_DHLD;
                else
                  after_ack <= AFT_RX;
                state <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_drv <= 1'b0;
              bitcnt  <= 4'h0;
              case (after_ack)
                AFT_RX:   state <= ST_SHIFT;
                AFT_DHLD: begin
                  byte_done_event_flag      <= 1'b1;
                  hold_src <= 1'b0;
                  state    <= ST_HOLD;
                end
                default:  state <= ST_IDLE;
              endcase
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Open-drain drives: only ever pull low
  assign scl_out = 1'b0;
  assign scl_oe  = stretch;
  assign sda_out = 1'b0;
  assign sda_oe  = sda_drv;

endmodule // tms_target

// ### hdl/tms_map.vh
// Register indices, field positions and reset values of the bus target
`ifndef TMS_MAP_VH
`define TMS_MAP_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define TMS_IDX_HOST_A     6'h03
`define TMS_IDX_CTRL       6'h0a
`define TMS_IDX_STATUS     6'h0b
`define TMS_IDX_ID         6'h0c
`define TMS_IDX_SHIFT      6'h0d
`define TMS_IDX_FILTER     6'h0e

// ==========================================================
// Field positions
`define TMS_HOST_EN_BIT    0
`define TMS_CTRL_EN_BIT    3
`define TMS_CTRL_ACK_BIT   2
`define TMS_ST_DIF_BIT     7
`define TMS_ST_MATCH_OR_HALT_EVENT_FLAG_BIT    6
`define TMS_ST_HOLD_BIT    5
`define TMS_ST_RXACK_BIT   4
`define TMS_ST_ERR_BIT     2
`define TMS_ST_DIR_BIT     1
`define TMS_ST_CAUSE_BIT   0
`define TMS_ID_GCALL_BIT   0
`define TMS_FILT_SEL_BIT   0

// ==========================================================
// Commands and reset values
`define TMS_CMD_NONE       2'h0
`define TMS_CMD_COMPLETE   2'h2
`define TMS_CMD_RESPOND    2'h3
`define TMS_REG_RESET      8'h00

`endif

// ### hdl/tms_line_watch.v
// Pin synchroniser and start, stop and clock edge detector
`timescale 1ns/1ps

module tms_line_watch (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire scl_in,
  input  wire sda_in,
  output wire scl_s,
  output wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_seen,
  output wire stop_seen
);

  // ==========================================================
  // Two-stage synchronisers, then one history stage
  reg [2:0] scl_q;
  reg [2:0] sda_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else if (ce) begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
    end
  end

  // ==========================================================
  // Conditions seen on settled lines only
  assign scl_s      = scl_q[1];
  assign sda_s      = sda_q[1];
  assign scl_rise   = scl_q[1] & ~scl_q[2];
  assign scl_fall   = ~scl_q[1] & scl_q[2];
  assign start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_seen  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

endmodule // tms_line_watch

// ### dv/tms_assertions.sv
// Concurrent checks on the ports of the bus target
`timescale 1ns/1ps

module tms_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_in,
  input wire        scl_oe,
  input wire        sda_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====
  // Helpers
  wire [5:0] idx   = paddr[7:2];
  wire       acc   = psel && penable && ce;
  wire       setup = psel && !penable && ce;
  wire       known = idx == 6'h03 || (idx >= 6'h0a && idx <= 6'h0e);
  wire       rel   = acc && (idx == 6'h0d || (pwrite && idx == 6'h0a));
  // ====
  // Checks
  chk_ready_ce: assert property (pready == ce)
    else $error("pready does not follow ce");
  chk_err_unmapped: assert property (acc && !known |-> pslverr)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (acc && known |-> !pslverr)
    else $error("mapped access refused");
  chk_unmapped_zero: assert property (setup && !known |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_hold_status: assert property (setup && idx == 6'h0b |=> prdata[5] == $past(scl_oe))
    else $error("stretch bit differs from clock drive");
  chk_hold_release: assert property (scl_oe && acc && idx == 6'h0d |-> ##[1:2] !scl_oe)
    else $error("data access did not release clock");
  // Only a data access or control write may end the stretch
  chk_hold_kept: assert property (scl_oe && !rel && !$past(rel) |=> scl_oe)
    else $error("clock released without access");
  chk_sda_steady: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
endmodule // tms_assertions

bind tms_target tms_assertions u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe));

// ### dv/tms_bus_ctrl.sv
// Behavioural bus controller driving the clock and data wires
`timescale 1ns/1ps

module tms_bus_ctrl (
  input  wire pclk,
  input  wire scl,
  input  wire sda,
  output reg  scl_oe,
  output reg  sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // ====
  // Line primitives, half a 320 ns link period each
  task half;
    repeat (4) @(posedge pclk);
  endtask
  // Clock release waits for the wire, so a stretching target stalls us
  task bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    half;
    scl_oe <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    r = sda;
    scl_oe <= 1'b1;
  endtask
  // Only used from an idle bus
  task start;
    sda_oe <= 1'b1;
    half;
    scl_oe <= 1'b1;
    half;
  endtask
  task stop;
    sda_oe <= 1'b1;
    half;
    scl_oe <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1) @(posedge pclk);
    half;
    sda_oe <= 1'b0;
    half;
  endtask
  task put(input logic [7:0] d, output logic nak);
    integer i;
    for (i = 7; i >= 0; i--) bit_io(d[i], nak);
    bit_io(1'b1, nak);
  endtask
  task get(input logic nak, output logic [7:0] d);
    integer i;
    logic   r;
    for (i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule // tms_bus_ctrl

// ### dv/tms_target_tb_top.sv
// Self-checking bench of the bus target
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tms_target_tb_top;
  localparam logic [7:0] a_host = 8'h0c, a_ctl = 8'h28, a_st = 8'h2c;
  localparam logic [7:0] a_id = 8'h30, a_sh = 8'h34, a_fi = 8'h38;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd;
  logic        er;
  logic        ak;
  logic [7:0]  by;
  int          bad_count = 0;
  int          n_compared = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda;
  wire         scl = ~((scl_oe & ~scl_o) | m_scl);
  wire         sda = ~((sda_oe & ~sda_o) | m_sda);

  tms_target dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe));
  tms_bus_ctrl bus (.pclk(pclk), .scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));

  initial begin
    forever #20 pclk = ~pclk;
  end
  initial begin
    #2000000;
    bad_count++;
    report_and_stop;
  end
  // ====
  // Shared tasks
  task apb(input logic w, input logic [7:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Skip the cycle in which a just-released stretch still shows
  task hold_wait;
    repeat (3) @(posedge pclk);
    while (scl_oe !== 1'b1) @(posedge pclk);
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====
  // Scenarios
  task t_regs;
    apb(0, a_id, 8'h00);
    `CHK(rd, 32'h0000_0000)
    apb(0, a_fi, 8'h00);
    `CHK(rd, 32'h0000_0000)
    apb(1, a_fi, 8'h5b);
    apb(1, a_sh, 8'h77);
    apb(0, a_fi, 8'h00);
    `CHK(rd[7:0], 8'h5b)
    apb(0, a_sh, 8'h00);
    `CHK(rd[7:0], 8'h00)
    apb(0, 8'h3c, 8'h00);
    `CHK(er, 1'b1)
  endtask
  task t_write(input logic [7:0] id, fi, ab, d);
    apb(1, a_ctl, 8'h08);
    apb(1, a_id, id);
    apb(1, a_fi, fi);
    fork
      begin
        bus.start;
        bus.put(ab, ak);
        `CHK(ak, 1'b0)
        bus.put(d, ak);
        `CHK(ak, 1'b0)
        bus.stop;
      end
      begin
        hold_wait;
        apb(0, a_st, 8'h00);
        `CHK(rd[7:0] & 8'he7, 8'h61)
        apb(1, a_ctl, 8'h0b);
        hold_wait;
        apb(0, a_st, 8'h00);
        `CHK(rd[7:0] & 8'he6, 8'ha0)
        apb(0, a_sh, 8'h00);
        `CHK(rd[7:0], d)
      end
    join
    apb(0, a_st, 8'h00);
    `CHK(rd[7:0] & 8'hc7, 8'h40)
    apb(1, a_st, 8'hc4);
  endtask
  task t_read;
    apb(1, a_fi, 8'h45);
    fork
      begin
        bus.start;
        bus.put(8'h45, ak);
        `CHK(ak, 1'b0)
        bus.get(1'b1, by);
        `CHK(by, 8'ha5)
        bus.stop;
      end
      begin
        hold_wait;
        apb(0, a_st, 8'h00);
        `CHK(rd[7:0] & 8'he7, 8'h63)
        apb(0, a_sh, 8'h00);
        hold_wait;
        apb(1, a_sh, 8'ha5);
        hold_wait;
        apb(0, a_st, 8'h00);
        `CHK(rd[7:0] & 8'hf0, 8'hb0)
        apb(1, a_ctl, 8'h0a);
      end
    join
    apb(1, a_st, 8'hc4);
  endtask
  task t_refuse(input logic [7:0] ctl, ab);
    apb(1, a_ctl, ctl);
    apb(1, a_id, 8'ha0);
    fork
      begin
        bus.start;
        bus.put(ab, ak);
        `CHK(ak, 1'b1)
        bus.stop;
      end
      if (ab == 8'ha0) begin
        hold_wait;
        apb(0, a_sh, 8'h00);
      end
    join
    apb(0, a_st, 8'h00);
    `CHK(rd[7:0] & 8'hc0, (ab == 8'ha0) ? 8'h40 : 8'h00)
  endtask
  // Stop right after start, then stop in mid-byte, each with and without host enable
  task t_bus_err;
    int h;
    int k;
    for (h = 0; h < 2; h++) begin
      apb(1, a_host, h[7:0]);
      for (k = 0; k < 4; k += 3) begin
        bus.start;
        repeat (k) bus.bit_io(1'b1, ak);
        bus.stop;
        apb(0, a_st, 8'h00);
        `CHK(rd[2], h[0])
        apb(1, a_st, 8'h00);
        apb(0, a_st, 8'h00);
        `CHK(rd[2], h[0])
        apb(1, a_st, 8'h04);
        apb(0, a_st, 8'h00);
        `CHK(rd[2], 1'b0)
      end
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_write(8'ha0, 8'h02, 8'ha2, 8'h3c);
    t_write(8'hf4, 8'h00, 8'hf4, 8'hc5);
    // Legal stops must leave the error flag clear
    apb(1, a_host, 8'h01);
    t_write(8'ha1, 8'h00, 8'h00, 8'h5a);
    t_read;
    t_refuse(8'h08, 8'ha2);
    t_refuse(8'h0c, 8'ha0);
    t_bus_err;
    report_and_stop;
  end
endmodule // tms_target_tb_top
